// *** rtl/pcg_pkg.sv ***
// package: register map, widths and reset values for the port c gpio block
package pcg_pkg;
  localparam int PCG_ADDR_W = 12;
  localparam logic [11:0] PCG_OFS_DATA = 12'h000;
  localparam logic [11:0] PCG_OFS_DIR = 12'h004;
  localparam logic [11:0] PCG_OFS_PULL = 12'h008;
  localparam logic [11:0] PCG_OFS_SLEW = 12'h00C;
  localparam logic [11:0] PCG_OFS_DRIVE = 12'h010;
  localparam logic [11:0] PCG_OFS_GANG = 12'h014;
  localparam int PCG_GANG_EN_BIT = 0;
  localparam logic [7:0] PCG_RST_ZERO = 8'h00;
  localparam logic [31:0] PCG_RDATA_ZERO = 32'h00000000;
endpackage : pcg_pkg

// *** rtl/pcg_port.sv ***
// port c gpio with ganged output drive, apb slave
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - direction 0: driver off, data read returns pin level
// - direction 1: driver on, data read returns latched output
// - pull-up on only when bit set and pin is input
// - slew limiting per bit, meaningful only for outputs
// - drive strength per bit, meaningful only for outputs
// - gang member bits 7..1 write-once, effective only with gang enable
// - gang members copy pin zero data, drive and slew
// - gang enable at bit 0 is write-once
// - gang enable forces pin zero to output
// - data writes latch all bits; outputs read back latch and drive it, except gang members, which drive pin zero data
// - reset clears data latch and makes all pins inputs without pull
module pcg_port
  import pcg_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [PCG_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n_out,
  output logic [PINS-1:0] pull_up_out,
  output logic [PINS-1:0] slew_out,
  output logic [PINS-1:0] drive_high_out
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_en;
  logic acc_en;
  logic hit;
  assign acc_en = psel_in && penable_in && ce_in;
  assign wr_en = acc_en && pwrite_in && pstrb_in[0];
  always_comb begin
    case (paddr_in)
      PCG_OFS_DATA, PCG_OFS_DIR, PCG_OFS_PULL, PCG_OFS_SLEW, PCG_OFS_DRIVE,
      PCG_OFS_GANG: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [PINS-1:0] data_latch_reg;
  logic [PINS-1:0] dir_reg;
  logic [PINS-1:0] pull_reg;
  logic [PINS-1:0] slew_reg;
  logic [PINS-1:0] drive_reg;
  logic [PINS-1:0] gang_reg;
  logic [PINS-1:0] gang_locked_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_latch_reg <= PCG_RST_ZERO[PINS-1:0];
    end else if (wr_en && paddr_in == PCG_OFS_DATA) begin
      data_latch_reg <= pwdata_in[PINS-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dir_reg <= PCG_RST_ZERO[PINS-1:0];
      pull_reg <= PCG_RST_ZERO[PINS-1:0];
      slew_reg <= PCG_RST_ZERO[PINS-1:0];
      drive_reg <= PCG_RST_ZERO[PINS-1:0];
    end else if (wr_en) begin
      if (paddr_in == PCG_OFS_DIR) dir_reg <= pwdata_in[PINS-1:0];
      if (paddr_in == PCG_OFS_PULL) pull_reg <= pwdata_in[PINS-1:0];
      if (paddr_in == PCG_OFS_SLEW) slew_reg <= pwdata_in[PINS-1:0];
      if (paddr_in == PCG_OFS_DRIVE) drive_reg <= pwdata_in[PINS-1:0];
    end
  end

  // each gang control bit locks on its first write
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gen_gang
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          gang_reg[g] <= 1'b0;
          gang_locked_reg[g] <= 1'b0;
        end else if (wr_en && paddr_in == PCG_OFS_GANG && !gang_locked_reg[g]) begin
          gang_reg[g] <= pwdata_in[g];
          gang_locked_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin control
  // ---------------------------------------------------------------
  logic gang_on;
  logic [PINS-1:0] member;
  logic [PINS-1:0] eff_dir;
  logic [PINS-1:0] eff_data;
  logic [PINS-1:0] eff_slew;
  logic [PINS-1:0] eff_drive;
  assign gang_on = gang_reg[PCG_GANG_EN_BIT];
  always_comb begin
    member = gang_reg & {PINS{gang_on}};
    member[0] = 1'b0;
    eff_dir = dir_reg;
    eff_dir[0] = dir_reg[0] | gang_on;
    eff_data = (data_latch_reg & ~member) | ({PINS{data_latch_reg[0]}} & member);
    eff_slew = (slew_reg & ~member) | ({PINS{slew_reg[0]}} & member);
    eff_drive = (drive_reg & ~member) | ({PINS{drive_reg[0]}} & member);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out <= PCG_RST_ZERO[PINS-1:0];
      pin_oe_n_out <= ~PCG_RST_ZERO[PINS-1:0];
      pull_up_out <= PCG_RST_ZERO[PINS-1:0];
      slew_out <= PCG_RST_ZERO[PINS-1:0];
      drive_high_out <= PCG_RST_ZERO[PINS-1:0];
    end else if (ce_in) begin
      pin_out <= eff_data;
      pin_oe_n_out <= ~eff_dir;
      pull_up_out <= pull_reg & ~eff_dir;
      slew_out <= eff_slew & eff_dir;
      drive_high_out <= eff_drive & eff_dir;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = PCG_RDATA_ZERO;
    case (paddr_in)
      PCG_OFS_DATA: rd_mux[PINS-1:0] = (pin_in & ~eff_dir) | (data_latch_reg & eff_dir);
      PCG_OFS_DIR: rd_mux[PINS-1:0] = dir_reg;
      PCG_OFS_PULL: rd_mux[PINS-1:0] = pull_reg;
      PCG_OFS_SLEW: rd_mux[PINS-1:0] = slew_reg;
      PCG_OFS_DRIVE: rd_mux[PINS-1:0] = drive_reg;
      PCG_OFS_GANG: rd_mux[PINS-1:0] = gang_reg;
      default: rd_mux = PCG_RDATA_ZERO;
    endcase
  end
  assign prdata_out = rd_mux;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_gang_write;
    wr_en && paddr_in == PCG_OFS_GANG;
  endsequence
  sequence s_second_gang_write;
    ##[1:8] wr_en && paddr_in == PCG_OFS_GANG;
  endsequence

  a_input_no_drive: assert property (ce_in && !eff_dir[1] |=> pin_oe_n_out[1])
    else $error("input pin driven");
  a_output_readback: assert property (acc_en && !pwrite_in && paddr_in == PCG_OFS_DATA
    && dir_reg[2] |-> prdata_out[2] == data_latch_reg[2])
    else $error("output readback wrong");
  a_pull_only_input: assert property (pull_up_out[3] |-> pin_oe_n_out[3])
    else $error("pull on driven pin");
  a_slew_only_out: assert property (slew_out[4] |-> !pin_oe_n_out[4])
    else $error("slew on input pin");
  a_drive_only_out: assert property (drive_high_out[5] |-> !pin_oe_n_out[5])
    else $error("drive on input pin");
  a_gang_follow: assert property (ce_in && gang_on && gang_reg[3]
    |=> pin_out[3] == $past(data_latch_reg[0]))
    else $error("gang member not following");
  a_gang_force_out: assert property (ce_in && gang_on |=> !pin_oe_n_out[0])
    else $error("pin zero not forced out");
  a_gang_write_once: assert property (s_gang_write ##0 s_second_gang_write
    |=> $stable(gang_reg))
    else $error("write-once bit changed");
  a_data_latch: assert property (wr_en && paddr_in == PCG_OFS_DATA
    |=> data_latch_reg == $past(pwdata_in[PINS-1:0]))
    else $error("data not latched");
  a_member_needs_en: assert property (!gang_on |-> member == PCG_RST_ZERO[PINS-1:0])
    else $error("member active without enable");
  a_reset_clear: assert property (disable iff (1'b0) rst_in |=> dir_reg == '0
    && gang_reg == '0 && data_latch_reg == '0)
    else $error("reset did not clear");
  a_reset_outputs: assert property (disable iff (1'b0) rst_in |=> &pin_oe_n_out
    && pull_up_out == '0 && pin_out == '0)
    else $error("reset left a pin driven");
  a_gang_lock_all: assert property (s_gang_write |=> &gang_locked_reg)
    else $error("gang bits not locked");
  a_gang_slew_follow: assert property (ce_in && gang_on && gang_reg[3]
    |=> slew_out[3] == $past(slew_reg[0] && eff_dir[3]))
    else $error("gang member slew not following");
  a_gang_drive_follow: assert property (ce_in && gang_on && gang_reg[3]
    |=> drive_high_out[3] == $past(drive_reg[0] && eff_dir[3]))
    else $error("gang member drive not following");
  a_unmapped_err: assert property (psel_in && penable_in && !hit
    |-> pslverr_out && prdata_out == PCG_RDATA_ZERO)
    else $error("unmapped access not refused");

  // ---------------------------------------------------------------
  // per-pin checks
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : gen_pin_chk
      a_pin_dir_oe: assert property (ce_in
        |=> pin_oe_n_out[p] == !$past(eff_dir[p]))
        else $error("pin enable does not follow direction");
      a_pin_pull_in: assert property (ce_in
        |=> pull_up_out[p] == $past(pull_reg[p] && !eff_dir[p]))
        else $error("pull-up setting wrong");
      a_pin_read_level: assert property (acc_en && !pwrite_in && paddr_in == PCG_OFS_DATA
        && !eff_dir[p] |-> prdata_out[p] == pin_in[p])
        else $error("input pin read wrong");
      a_pin_read_latch: assert property (acc_en && !pwrite_in && paddr_in == PCG_OFS_DATA
        && eff_dir[p] |-> prdata_out[p] == data_latch_reg[p])
        else $error("output pin read wrong");
    end
  endgenerate

endmodule : pcg_port

// *** testbench/pcg_pins.sv ***
// external circuitry model for the port c pins
`timescale 1ns/1ps
module pcg_pins (
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] level_out
);
  // a driven pin shows the device level, a released pin the outside source
  assign level_out = (drv_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule : pcg_pins

// *** testbench/pcg_port_test.sv ***
// self-checking bench for the port c gpio block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module pcg_port_test;
  import pcg_pkg::*;
  logic clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h16;
  logic [7:0] ext = 8'h00, pin, pout, oe_n, pull, slew, drv, d, r, p, s, v;
  logic [32:0] q[$];
  logic [32:0] e;
  int num_errors = 0, n_compared = 0;
  always #12.5 clk_in = ~clk_in;
  pcg_port pcg_port_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pin_in(pin),
    .pin_out(pout), .pin_oe_n_out(oe_n), .pull_up_out(pull), .slew_out(slew),
    .drive_high_out(drv));
  pcg_pins pcg_pins_inst (.drv_in(pout), .oe_n_in(oe_n), .ext_in(ext), .level_out(pin));
  // ----------------------------------------
  // apb master and read checker
  // ----------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
                     input logic [32:0] ex);
    @(posedge clk_in);
    if (!w) q.push_back(ex);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk_in);
    pen <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] wd);
    apb(1'b1, a, wd, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic er);
    apb(1'b0, a, 8'h00, {er, 24'h000000, x});
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle
  always @(posedge clk_in) begin
    if (psel && pen && pready && !pwr) begin
      e = q.pop_front();
      `CHK({pslverr, prdata}, e)
    end
  end
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge clk_in);
    num_errors++;
    stop_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    settle();
    `CHK({oe_n, pout, pull, slew, drv}, {8'hFF, 32'h0})
    for (int i = 0; i < 6; i++) rd(12'(4 * i), 8'h00, 1'b0);
    rd(12'h018, 8'h00, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = xs();
      r = xs();
      p = xs();
      s = xs();
      v = xs();
      @(posedge clk_in);
      ext <= xs();
      wr(PCG_OFS_DATA, d);
      wr(PCG_OFS_DIR, r);
      wr(PCG_OFS_PULL, p);
      wr(PCG_OFS_SLEW, s);
      wr(PCG_OFS_DRIVE, v);
      settle();
      rd(PCG_OFS_DATA, (d & r) | (ext & ~r), 1'b0);
      `CHK({oe_n, pout & r, pull}, {~r, d & r, p & ~r})
      `CHK({slew & r, drv & r}, {s & r, v & r})
    end
    // gang of pins 1 and 3 on pin zero, pin zero direction left as input
    wr(PCG_OFS_DATA, 8'h01);
    wr(PCG_OFS_DIR, 8'h0A);
    wr(PCG_OFS_SLEW, 8'h01);
    wr(PCG_OFS_DRIVE, 8'h01);
    wr(PCG_OFS_GANG, 8'h0B);
    settle();
    `CHK({oe_n[0], pout & 8'h0F, slew & 8'h0B, drv & 8'h0B}, {1'b0, 8'h0B, 16'h0B0B})
    rd(PCG_OFS_DATA, 8'h01 | (ext & 8'hF4), 1'b0);
    wr(PCG_OFS_GANG, 8'h00);
    rd(PCG_OFS_GANG, 8'h0B, 1'b0);
    settle();
    `CHK({oe_n[0], pout[3]}, 2'b01)
    stop_test();
  end
endmodule : pcg_port_test
